// ===== rtl/ccop_ctrl.sv
// Purpose: Block and global cache coherence operation control, fence stall.
// Assumes: Register writes arrive as one-cycle strobes synchronous to CLK_I.
// Notes:   Global ops run one at a time, lowest index first.
`default_nettype none

module ccop_ctrl
	import ccop_pkg::*;
#(
	parameter int unsigned GLB_LINES = GLB_LINES_DEF
) (
	input  wire logic              CLK_I,
	input  wire logic              RESETN_I,
	input  wire logic              BASE_WR_I,
	input  wire logic [ADDR_W-1:0] BASE_DATA_I,
	input  wire ccop_op_e          BLOCK_OP_I,
	input  wire logic              COUNT_WR_I,
	input  wire logic [CNT_W-1:0]  COUNT_DATA_I,
	output logic [ADDR_W-1:0]      BASE_ADDR_O,
	output logic [CNT_W-1:0]       BLOCK_WORD_COUNT_O,
	input  wire logic [GLB_N-1:0]  GLB_WR_I,
	input  wire logic [GLB_N-1:0]  GLB_WDATA0_I,
	output logic [GLB_N-1:0]       GLB_BUSY_O,
	input  wire logic              FENCE_REQ_I,
	output logic                   FENCE_STALL_O,
	input  wire logic              L1D_FREEZE_I,
	output logic                   L1D_FROZEN_O,
	output ccop_req_s              BLK_REQ_O,
	output logic                   BLK_REQ_VALID_O,
	input  wire logic              BLK_REQ_READY_I,
	output ccop_req_s              GLB_REQ_O,
	output logic                   GLB_REQ_VALID_O,
	input  wire logic              GLB_REQ_READY_I
);

	localparam int unsigned GCW = $clog2(GLB_LINES + 1);
	localparam logic [GCW-1:0] GLB_COUNT = GCW'(GLB_LINES);

	// Table of the four global operations
	localparam ccop_op_e GLB_OP_TBL [GLB_N] = '{
		OP_L1D_INV, OP_L1D_WRITEBACK_INVALIDATE_OP, OP_L2_INV, OP_L2_WRITEBACK_INVALIDATE_OP
	};

	generate
		if (GLB_LINES < 1 || GCW > ADDR_W) begin : g_chk
			$error("ccop_ctrl: GLB_LINES out of range");
		end
	endgenerate

	logic [1:0]         rst_sync_q;
	logic               rst_n;
	logic [ADDR_W-1:0]  base_q;
	ccop_op_e           blk_op_q;
	logic               blk_valid;
	logic [ADDR_W-1:0]  blk_addr;
	logic [CNT_W-1:0]   blk_remain;
	logic               blk_start;
	logic [GLB_N-1:0]   glb_trig;
	logic [GLB_N-1:0]   pend_q;
	logic [GLB_N-1:0]   busy_q;
	logic [GLB_N-1:0]   sel;
	logic [1:0]         sel_idx;
	logic [1:0]         act_q;
	ccop_op_e           act_op_q;
	ccop_gstate_e       gstate_q;
	logic               glb_start;
	logic               glb_done;
	logic               glb_valid;
	logic [ADDR_W-1:0]  glb_addr;
	logic [GCW-1:0]     glb_remain;
	logic               any_busy;
	logic               stall_q;
	logic               frozen_q;

	// Reset is released through two flops so its deassertion is clean
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Base address register; always writable, the walker holds its own copy
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			base_q <= ADDR_RST;
		end else if (BASE_WR_I) begin
			base_q <= BASE_DATA_I;
		end
	end

	// Launch only from idle; a count write during a walk is dropped
	assign blk_start = COUNT_WR_I && (blk_remain == CNT_RST);

	// Operation kind is latched with the launch
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			blk_op_q <= OP_L1D_INV;
		end else if (blk_start) begin
			blk_op_q <= BLOCK_OP_I;
		end
	end

	ccop_walker #(
		.AW (ADDR_W),
		.CW (CNT_W)
	) u_blk (
		.clk_i    (CLK_I),
		.rst_n_i  (rst_n),
		.start_i  (blk_start),
		.base_i   (base_q),
		.count_i  (COUNT_DATA_I),
		.step_i   (WORD_BYTES),
		.ready_i  (BLK_REQ_READY_I),
		.valid_o  (blk_valid),
		.addr_o   (blk_addr),
		.remain_o (blk_remain),
		.done_o   ()
	);

	// Per-op pending and busy bits; a trigger beats a same-cycle clear
	generate
		for (genvar i = 0; i < GLB_N; i++) begin : g_glb
			assign glb_trig[i] = GLB_WR_I[i] && GLB_WDATA0_I[i];

			always_ff @(posedge CLK_I or negedge rst_n) begin
				if (!rst_n) begin
					pend_q[i] <= 1'b0;
				end else if (glb_trig[i]) begin
					pend_q[i] <= 1'b1;
				end else if (glb_start && sel[i]) begin
					pend_q[i] <= 1'b0;
				end
			end

			always_ff @(posedge CLK_I or negedge rst_n) begin
				if (!rst_n) begin
					busy_q[i] <= 1'b0;
				end else if (glb_trig[i]) begin
					busy_q[i] <= 1'b1;
				end else if (glb_done && act_q == 2'(i) && !pend_q[i]) begin
					busy_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Fixed priority pick of the lowest pending op
	always_comb begin
		sel     = '0;
		sel_idx = 2'h0;
		for (int k = GLB_N - 1; k >= 0; k--) begin
			if (pend_q[k]) begin
				sel     = '0;
				sel[k]  = 1'b1;
				sel_idx = 2'(k);
			end
		end
	end

	assign glb_start = (gstate_q == G_IDLE) && (|pend_q);

	// Global sequencer: one whole-cache walk at a time
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			gstate_q <= G_IDLE;
			act_q    <= 2'h0;
			act_op_q <= OP_L1D_INV;
		end else begin
			case (gstate_q)
				G_IDLE: begin
					if (glb_start) begin
						gstate_q <= G_RUN;
						act_q    <= sel_idx;
						// Op kind held in a flop so the port needs no decode
						act_op_q <= GLB_OP_TBL[sel_idx];
					end
				end
				G_RUN: begin
					if (glb_done) begin
						gstate_q <= G_IDLE;
					end
				end
				default: begin
					gstate_q <= G_IDLE;
				end
			endcase
		end
	end

	ccop_walker #(
		.AW (ADDR_W),
		.CW (GCW)
	) u_glb (
		.clk_i    (CLK_I),
		.rst_n_i  (rst_n),
		.start_i  (glb_start),
		.base_i   (ADDR_RST),
		.count_i  (GLB_COUNT),
		.step_i   (GLB_STEP),
		.ready_i  (GLB_REQ_READY_I),
		.valid_o  (glb_valid),
		.addr_o   (glb_addr),
		.remain_o (glb_remain),
		.done_o   (glb_done)
	);

	// Anything outstanding, including a launch arriving this cycle
	assign any_busy = (blk_remain != CNT_RST) || blk_start
		|| (|busy_q) || (|glb_trig);

	// Fence stall is registered, so it rises one cycle after the request
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= FENCE_REQ_I && any_busy;
		end
	end

	// Freeze only gates L1D allocation; the core itself is never held
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			frozen_q <= 1'b0;
		end else begin
			frozen_q <= L1D_FREEZE_I;
		end
	end

	assign BASE_ADDR_O        = base_q;
	assign BLOCK_WORD_COUNT_O = blk_remain;
	assign GLB_BUSY_O         = busy_q;
	assign FENCE_STALL_O      = stall_q;
	assign L1D_FROZEN_O       = frozen_q;
	assign BLK_REQ_VALID_O    = blk_valid;
	assign BLK_REQ_O          = '{glob: 1'b0, op: blk_op_q, addr: blk_addr};
	assign GLB_REQ_VALID_O    = glb_valid;
	assign GLB_REQ_O          = '{glob: 1'b1, op: act_op_q,
		addr: glb_addr};

endmodule

`default_nettype wire

// ===== rtl/ccop_pkg.sv
// Purpose: Shared constants and types for the cache coherence op control.
// Assumes: One clock, word-granular block operations on a 32-bit address.
// Notes:   Rules that the control logic and its software users follow.
`default_nettype none

package ccop_pkg;

	localparam int unsigned ADDR_W        = 32;
	localparam int unsigned CNT_W         = 16;
	localparam int unsigned GLB_N         = 4;
	localparam int unsigned GLB_LINES_DEF = 1024;

	localparam logic [ADDR_W-1:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [ADDR_W-1:0] GLB_STEP   = 32'h0000_0001;
	localparam logic [ADDR_W-1:0] ADDR_RST   = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0000;

	// Index of each global trigger register
	localparam int unsigned GLB_L1D_INV   = 0;
	localparam int unsigned GLB_L1D_WRITEBACK_INVALIDATE_OP = 1;
	localparam int unsigned GLB_L2_INV    = 2;
	localparam int unsigned GLB_L2_WRITEBACK_INVALIDATE_OP  = 3;

	typedef enum logic [2:0] {
		OP_L1D_INV   = 3'h0,
		OP_L1D_WB    = 3'h1,
		OP_L1D_WRITEBACK_INVALIDATE_OP = 3'h2,
		OP_L2_INV    = 3'h3,
		OP_L2_WB     = 3'h4,
		OP_L2_WRITEBACK_INVALIDATE_OP  = 3'h5
	} ccop_op_e;

	typedef enum logic [1:0] {
		G_IDLE = 2'b01,
		G_RUN  = 2'b10
	} ccop_gstate_e;

	// One word (block) or one line index (global) for the cache to process
	typedef struct packed {
		logic                glob;
		ccop_op_e            op;
		logic [ADDR_W-1:0]   addr;
	} ccop_req_s;

endpackage

`default_nettype wire

// ===== rtl/ccop_walker.sv
// Purpose: Steps an address over a count of items, one per accepted request.
// Assumes: ready_i high means the cache has finished the offered item.
// Notes:   A start while the walk is running is ignored.
`default_nettype none

module ccop_walker #(
	parameter int unsigned AW = 32,
	parameter int unsigned CW = 16
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          start_i,
	input  wire logic [AW-1:0] base_i,
	input  wire logic [CW-1:0] count_i,
	input  wire logic [AW-1:0] step_i,
	input  wire logic          ready_i,
	output logic               valid_o,
	output logic [AW-1:0]      addr_o,
	output logic [CW-1:0]      remain_o,
	output logic               done_o
);

	logic          valid_q;
	logic [AW-1:0] addr_q;
	logic [CW-1:0] remain_q;
	logic          done_q;
	logic          last;

	generate
		if (AW < 1 || CW < 1) begin : g_chk
			$error("ccop_walker: widths must be at least one bit");
		end
	endgenerate

	// Cast keeps the compare legal for a one-bit counter as well
	assign last = (remain_q == CW'(1));

	// Walk state; the address is a private copy so later base writes
	// cannot disturb the walk under way
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_q  <= 1'b0;
			addr_q   <= '0;
			remain_q <= '0;
		end else if (remain_q == '0) begin
			if (start_i && count_i != '0) begin
				valid_q  <= 1'b1;
				addr_q   <= base_i;
				remain_q <= count_i;
			end
		end else if (valid_q && ready_i) begin
			remain_q <= remain_q - 1'b1;
			addr_q   <= addr_q + step_i;
			if (last) begin
				valid_q <= 1'b0;
			end
		end
	end

	// One-cycle completion pulse on the last accepted item
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= valid_q && ready_i && last;
		end
	end

	assign valid_o  = valid_q;
	assign addr_o   = addr_q;
	assign remain_o = remain_q;
	assign done_o   = done_q;

endmodule

`default_nettype wire

// ===== testbench/ccop_ctrl_assertions.sv
// Purpose: Port checks for the coherence op control.
// Assumes: One clock; RESETN_I low keeps everything quiet.
// Notes:   Bound to every ccop_ctrl instance.
`default_nettype none
module ccop_ctrl_assertions
	import ccop_pkg::*;
#(
	parameter int unsigned GLB_LINES = 4
) (
	input wire logic              CLK_I,
	input wire logic              RESETN_I,
	input wire logic              COUNT_WR_I,
	input wire logic [CNT_W-1:0]  COUNT_DATA_I,
	input wire logic [CNT_W-1:0]  BLOCK_WORD_COUNT_O,
	input wire logic [GLB_N-1:0]  GLB_WR_I,
	input wire logic [GLB_N-1:0]  GLB_WDATA0_I,
	input wire logic [GLB_N-1:0]  GLB_BUSY_O,
	input wire logic              FENCE_REQ_I,
	input wire logic              FENCE_STALL_O,
	input wire logic              L1D_FREEZE_I,
	input wire logic              L1D_FROZEN_O,
	input wire ccop_req_s         BLK_REQ_O,
	input wire logic              BLK_REQ_VALID_O,
	input wire logic              BLK_REQ_READY_I,
	input wire ccop_req_s         GLB_REQ_O,
	input wire logic              GLB_REQ_VALID_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Launch, accept and trigger conditions seen at the ports
	logic             launch;
	logic             take;
	logic [GLB_N-1:0] trig;
	assign launch = COUNT_WR_I && BLOCK_WORD_COUNT_O == CNT_RST
		&& COUNT_DATA_I != CNT_RST;
	assign take = BLK_REQ_VALID_O && BLK_REQ_READY_I;
	assign trig = GLB_WR_I & GLB_WDATA0_I;
	sequence s_last_word;
		take && BLOCK_WORD_COUNT_O == 16'h0001;
	endsequence
	sequence s_block_idle;
		!BLK_REQ_VALID_O && BLOCK_WORD_COUNT_O == CNT_RST;
	endsequence
	a_count_load: assert property (launch |=>
		BLOCK_WORD_COUNT_O == $past(COUNT_DATA_I)) else $error("no load");
	a_count_step: assert property (take |=>
		BLOCK_WORD_COUNT_O == $past(BLOCK_WORD_COUNT_O) - 16'h0001)
		else $error("count step wrong");
	a_count_hold: assert property (!take && !launch |=>
		$stable(BLOCK_WORD_COUNT_O)) else $error("count moved");
	a_block_end: assert property (s_last_word |=> s_block_idle)
		else $error("block op not ended");
	a_addr_step: assert property (take && BLOCK_WORD_COUNT_O > 16'h0001
		|=> BLK_REQ_O.addr == $past(BLK_REQ_O.addr) + WORD_BYTES)
		else $error("word address step wrong");
	a_glb_start: assert property (trig != '0 |=>
		(GLB_BUSY_O & $past(trig)) == $past(trig)) else $error("no busy");
	a_glb_cause: assert property (1'b1 |=> (GLB_BUSY_O
		& ~$past(GLB_BUSY_O) & ~$past(trig)) == '0) else $error("busy");
	a_glb_line: assert property (GLB_REQ_VALID_O |-> GLB_REQ_O.glob
		&& GLB_REQ_O.addr < GLB_LINES && GLB_BUSY_O != '0)
		else $error("bad global line");
	a_fence_hold: assert property (FENCE_REQ_I && (GLB_BUSY_O != '0
		|| BLOCK_WORD_COUNT_O != CNT_RST) |=> FENCE_STALL_O)
		else $error("fence not stalled");
	a_fence_free: assert property (!FENCE_REQ_I |=> !FENCE_STALL_O)
		else $error("stall without fence");
	a_freeze_copy: assert property (1'b1 |=>
		L1D_FROZEN_O == $past(L1D_FREEZE_I)) else $error("freeze lag");
endmodule
bind ccop_ctrl ccop_ctrl_assertions #(.GLB_LINES(GLB_LINES)) u_chk (
	.CLK_I(CLK_I), .RESETN_I(RESETN_I), .COUNT_WR_I(COUNT_WR_I),
	.COUNT_DATA_I(COUNT_DATA_I), .BLOCK_WORD_COUNT_O(BLOCK_WORD_COUNT_O),
	.GLB_WR_I(GLB_WR_I), .GLB_WDATA0_I(GLB_WDATA0_I),
	.GLB_BUSY_O(GLB_BUSY_O), .FENCE_REQ_I(FENCE_REQ_I),
	.FENCE_STALL_O(FENCE_STALL_O), .L1D_FREEZE_I(L1D_FREEZE_I),
	.L1D_FROZEN_O(L1D_FROZEN_O), .BLK_REQ_O(BLK_REQ_O),
	.BLK_REQ_VALID_O(BLK_REQ_VALID_O), .BLK_REQ_READY_I(BLK_REQ_READY_I),
	.GLB_REQ_O(GLB_REQ_O), .GLB_REQ_VALID_O(GLB_REQ_VALID_O));
`default_nettype wire

// ===== testbench/ccop_cache_model.sv
// Purpose: Cache side that finishes offered words or lines.
// Assumes: lat_i extra cycles per item; ready is one cycle long.
// Notes:   Counts accepted items and keeps the last one.
`default_nettype none
module ccop_cache_model
	import ccop_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [1:0] lat_i,
	input wire logic       valid_i,
	input wire ccop_req_s  req_i,
	output logic           ready_o,
	output var int         n_o,
	output ccop_req_s      last_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] w_q;
	// Ready drops after each accept so slow and fast answers both occur
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready_o <= 1'b0;
			w_q     <= 2'h0;
			n_o     <= 0;
			last_o  <= '0;
		end else if (ready_o && valid_i) begin
			ready_o <= 1'b0;
			w_q     <= 2'h0;
			n_o     <= n_o + 1;
			last_o  <= req_i;
		end else if (valid_i && w_q >= lat_i) begin
			ready_o <= 1'b1;
		end else if (valid_i) begin
			w_q <= w_q + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Directed bench for the coherence op control.
// Assumes: Inputs change on the falling edge; GLB_LINES is 4.
// Notes:   Block, global, fence and frozen flows.
`default_nettype none
module tb_top
	import ccop_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam ccop_op_e GOP [4] = '{OP_L1D_INV, OP_L1D_WRITEBACK_INVALIDATE_OP,
		OP_L2_INV, OP_L2_WRITEBACK_INVALIDATE_OP};
	logic        clk, rst_n, bwr, cwr, fence, frz, brdy, grdy;
	logic        stall, frozen, bval, gval;
	logic [31:0] bdat, base_o;
	logic [15:0] cdat, cnt;
	logic [3:0]  gwr, gd, busy;
	logic [1:0]  lat;
	ccop_op_e    bop;
	ccop_req_s   breq, greq, blast, glast;
	int          bn, gn, n0, fails, samples_checked;
	ccop_ctrl #(.GLB_LINES(4)) ccop_ctrl_inst (.CLK_I(clk), .RESETN_I(rst_n),
		.BASE_WR_I(bwr), .BASE_DATA_I(bdat), .BLOCK_OP_I(bop),
		.COUNT_WR_I(cwr), .COUNT_DATA_I(cdat), .BASE_ADDR_O(base_o),
		.BLOCK_WORD_COUNT_O(cnt), .GLB_WR_I(gwr), .GLB_WDATA0_I(gd),
		.GLB_BUSY_O(busy), .FENCE_REQ_I(fence), .FENCE_STALL_O(stall),
		.L1D_FREEZE_I(frz), .L1D_FROZEN_O(frozen), .BLK_REQ_O(breq),
		.BLK_REQ_VALID_O(bval), .BLK_REQ_READY_I(brdy), .GLB_REQ_O(greq),
		.GLB_REQ_VALID_O(gval), .GLB_REQ_READY_I(grdy));
	ccop_cache_model ccop_cache_model_inst_b (.clk_i(clk), .rst_n_i(rst_n),
		.lat_i(lat), .valid_i(bval), .req_i(breq), .ready_o(brdy),
		.n_o(bn), .last_o(blast));
	ccop_cache_model ccop_cache_model_inst_g (.clk_i(clk), .rst_n_i(rst_n),
		.lat_i(2'h0), .valid_i(gval), .req_i(greq), .ready_o(grdy),
		.n_o(gn), .last_o(glast));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Compare and count; unknowns never match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks=%0d fails=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One-cycle register strobes
	task automatic wr_base(input logic [31:0] a);
		bdat = a;
		bwr = 1'b1;
		tick(1);
		bwr = 1'b0;
	endtask
	task automatic wr_count(input ccop_op_e op, input logic [15:0] n);
		bop = op;
		cdat = n;
		cwr = 1'b1;
		tick(1);
		cwr = 1'b0;
	endtask
	task automatic trig(input int i, input logic d);
		gwr = 4'h1 << i;
		gd = {4{d}};
		tick(1);
		gwr = 4'h0;
	endtask
	// Polls like software would, but never forever
	task automatic wait_idle;
		int k;
		k = 0;
		while ((cnt !== CNT_RST || busy !== 4'h0) && k < 400) begin
			tick(1);
			k++;
		end
		if (k >= 400) begin
			fails++;
			end_sim();
		end
		tick(16);
	endtask
	initial begin
		{rst_n, bwr, cwr, fence, frz, cdat, gwr, gd, lat} = '0;
		bdat = 32'h0;
		bop = OP_L1D_INV;
		fails = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		tick(3);
		chk(cnt, 32'h0);
		chk(busy, 32'h0);
		// Every block kind, prompt cache
		for (int k = 0; k < 6; k++) begin
			n0 = bn;
			wr_base(32'h1000 + 32'(k) * 32'h100);
			wr_count(ccop_op_e'(k), 16'h0003);
			chk(cnt, 32'h3);
			wait_idle();
			chk(bn - n0, 32'h3);
			chk(blast.addr, 32'h1008 + 32'(k) * 32'h100);
			chk(blast.op, k);
			chk(blast.glob, 32'h0);
		end
		// Slow cache: base rewrite and count write while running, fence
		lat = 2'h3;
		n0 = bn;
		wr_base(32'h2000);
		wr_count(OP_L2_WB, 16'h0004);
		wr_base(32'h3000);
		wr_count(OP_L2_WB, 16'h0005);
		fence = 1'b1;
		tick(2);
		chk(stall, 32'h1);
		wait_idle();
		tick(1);
		chk(stall, 32'h0);
		fence = 1'b0;
		chk(bn - n0, 32'h4);
		chk(blast.addr, 32'h200c);
		chk(base_o, 32'h3000);
		wr_count(OP_L2_WB, 16'h0001);
		wait_idle();
		chk(blast.addr, 32'h3000);
		lat = 2'h0;
		// Zero write is ignored, then each global op in turn
		trig(0, 1'b0);
		chk(busy, 32'h0);
		for (int i = 0; i < 4; i++) begin
			n0 = gn;
			trig(i, 1'b1);
			chk(busy, 32'h1 << i);
			wait_idle();
			chk(gn - n0, 32'h4);
			chk(glast.op, GOP[i]);
			chk(glast.addr, 32'h3);
			chk(glast.glob, 32'h1);
		end
		// Two ops at once, then a retrigger of the running one: it queues
		n0 = gn;
		gwr = 4'ha;
		gd = 4'hf;
		tick(1);
		gwr = 4'h0;
		chk(busy, 32'ha);
		tick(1);
		trig(1, 1'b1);
		chk(busy, 32'ha);
		wait_idle();
		chk(gn - n0, 32'hc);
		chk(glast.op, GOP[3]);
		// Frozen L1D: writeback-invalidate beside traffic, no stall
		fence = 1'b1;
		tick(2);
		chk(stall, 32'h0);
		fence = 1'b0;
		frz = 1'b1;
		tick(1);
		chk(frozen, 32'h1);
		wr_base(32'h4000);
		wr_count(OP_L1D_WRITEBACK_INVALIDATE_OP, 16'h0002);
		chk(stall, 32'h0);
		wait_idle();
		chk(blast.addr, 32'h4004);
		fence = 1'b1;
		tick(2);
		chk(stall, 32'h0);
		fence = 1'b0;
		frz = 1'b0;
		tick(1);
		chk(frozen, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
